// >>> common/mxio_map.vh
// Register indices, reset values and pin positions of the I/O port bank.
// Assumes APB with 32-bit words; byte address is four times the index.
`ifndef MXIO_MAP_VH
`define MXIO_MAP_VH

// Register indices
`define MXIO_IDX_P3_DATA 6'h00
`define MXIO_IDX_P3_DIR  6'h01
`define MXIO_IDX_P3_FN   6'h02
`define MXIO_IDX_P4_DATA 6'h03
`define MXIO_IDX_P4_DIR  6'h04
`define MXIO_IDX_P4_FN   6'h05
`define MXIO_IDX_P6_DATA 6'h06
`define MXIO_IDX_P6_DIR  6'h07
`define MXIO_IDX_P6_FN   6'h08
`define MXIO_IDX_P7_DATA 6'h09
`define MXIO_IDX_P7_DIR  6'h0a
`define MXIO_IDX_P7_FN   6'h0b
`define MXIO_IDX_P8_DATA 6'h0c
`define MXIO_IDX_P5_IN   6'h0d
`define MXIO_IDX_P8_DIR  6'h0e
`define MXIO_IDX_P8_FN   6'h0f
`define MXIO_IDX_P9_DATA 6'h10
`define MXIO_IDX_P9_DIR  6'h11
`define MXIO_IDX_P9_FN   6'h12
`define MXIO_IDX_P9_ODE  6'h13

// Address decode
`define MXIO_IDX_LSB  2
`define MXIO_IDX_MSB  7
`define MXIO_ADDR_MSB 11

// Reset values
`define MXIO_RST_P3_LAT 8'h00
`define MXIO_RST_P4_LAT 3'h3
`define MXIO_RST_P6_LAT 8'hff
`define MXIO_RST_P7_LAT 4'hf
`define MXIO_RST_P8_LAT 8'hff
`define MXIO_RST_P9_LAT 8'hff
`define MXIO_RST_P9_DIR 8'hc0
`define MXIO_RST_ZERO8  8'h00

// Pad control reset values, all 39 pins; port 9 bits 0-5 pulled up too
`define MXIO_RST_PIN_OUT 39'h00_0000_0003
`define MXIO_RST_PIN_PU  39'h1f_ffff_fbfc
`define MXIO_RST_PIN_PD  39'h00_0000_0400

// Fixed masks
`define MXIO_P3_OUT_ONLY 8'h03
`define MXIO_P4_RD_ONES  5'h1f
`define MXIO_P4_PU_MASK  3'h3
`define MXIO_P4_PD_MASK  3'h4
`define MXIO_P9_PU_MASK  8'h3f
`define MXIO_P9_OD_FIXED 8'hc0
`define MXIO_ALL_ONES8   8'hff
`define MXIO_ODE_W       2

`endif

// >>> design/mxio_pin.v
// Generic pin mux for one port: latch or peripheral value, drive and pulls.
// Assumes registered controls from the main block; purely combinational.
module mxio_pin #(
  parameter W = 8
) (
  input  wire [W-1:0] lat,
  input  wire [W-1:0] dir,
  input  wire [W-1:0] fn,
  input  wire [W-1:0] alt,
  input  wire [W-1:0] od,
  input  wire [W-1:0] pu_mask,
  input  wire [W-1:0] pd_mask,
  output wire [W-1:0] pin_o,
  output wire [W-1:0] pin_oe,
  output wire [W-1:0] pu_en,
  output wire [W-1:0] pd_en
);

  wire [W-1:0] val;

  // Peripheral value replaces the latch where the function bit is set
  assign val    = (fn & alt) | (~fn & lat);
  // direction 1 drives, open drain only pulls low
  assign pin_oe = dir & (~od | ~val);
  assign pin_o  = val & ~od;
  // in input mode the latch steers the pull resistor
  assign pu_en  = ~dir & lat & pu_mask;
  assign pd_en  = ~dir & ~lat & pd_mask;

endmodule // mxio_pin

// >>> design/mxio_ports.v
// I/O ports 3 to 9: latches, direction and function registers over APB,
// pin drivers, pulls and routing of peripheral signals.
// Assumes pins sampled synchronously to pclk; pad logic resolves oe/pulls.
`include "mxio_map.vh"

////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Port 3 bits 0,1 output only, high after reset; bits 2-7 pulled up.
// - Reset clears port 3 latch, direction, function; direction bits 0,1 unused.
// - Strobe function with latch 0 strobes every read, internal too.
// - Strobe function with latch 1 strobes only external area reads.
// - In input mode the data latch switches the pull resistor.
// - Port 4 bits 0,1 pull up, bit 2 pulls down; control cleared.
// - Port 4 data reads return ones in bits 7 to 3.
// - Port 5 is read-only input; converter picks its own channel.
// - Port 6 resets to pulled-up inputs, latch ones, function zero.
// - Port 6 function bits select transmit or clock; receive always routed.
// - Port 7 function bits route timer and PWM; bit 0 feeds timer 0.
// - Port 7 resets to pulled-up inputs, direction and function cleared.
// - Port 8 timer clock inputs always routed; flip-flop outputs need function.
// - Port 8 resets to pulled-up inputs, latch ones, control zero.
// - Port 9 bits 0-5 pulled-up inputs; function bits select serial roles.
// - Port 9 bits 6,7 open drain, latch and direction one, float.
// - Port 9 bits 0 and 3 offer programmable open drain transmit.
// - Direction bit 0 means input, 1 means output.
module mxio_ports (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        cpu_rd,
  input  wire        cpu_wr,
  input  wire        ext_area,
  input  wire [2:0]  bank_select_outputs,
  input  wire [7:2]  p3_alt_out,
  input  wire [2:0]  p6_txd_out,
  input  wire [1:0]  p6_sclk_out,
  input  wire        timer1_output,
  input  wire        pwm0_output,
  input  wire        pwm1_output,
  input  wire [2:0]  timer_ff_out,
  input  wire [1:0]  p9_txd_out,
  input  wire [1:0]  p9_sclk_out,
  input  wire [7:0]  p3_in,
  input  wire [2:0]  p4_in,
  input  wire [7:0]  p5_in,
  input  wire [7:0]  p6_in,
  input  wire [3:0]  p7_in,
  input  wire [7:0]  p8_in,
  input  wire [7:0]  p9_in,
  output wire [38:0] pin_o,
  output wire [38:0] pin_oe,
  output wire [38:0] pin_pu,
  output wire [38:0] pin_pd,
  output reg  [7:0]  port5_input_levels,
  output reg  [2:0]  serial_rxd_p6,
  output reg  [1:0]  serial_rxd_p9,
  output reg         timer0_clock_input,
  output reg  [3:0]  timer16_clk_in,
  output reg         external_irq0_input,
  output reg         slow_osc_in
);

  ////////////////////////////////////////////////////////////////////
  // Register state
  reg [7:0] p3_lat_q;
  reg [7:0] port3_direction_reg;
  reg [7:0] port3_function_reg;
  reg [2:0] p4_lat_q;
  reg [2:0] port4_direction_reg;
  reg [2:0] port4_function_reg;
  reg [7:0] p6_lat_q;
  reg [7:0] port6_direction_reg;
  reg [7:0] port6_function_reg;
  reg [3:0] p7_lat_q;
  reg [3:0] port7_direction_reg;
  reg [3:0] port7_function_reg;
  reg [7:0] p8_lat_q;
  reg [7:0] port8_direction_reg;
  reg [7:0] port8_function_reg;
  reg [7:0] p9_lat_q;
  reg [7:0] port9_direction_reg;
  reg [7:0] port9_function_reg;
  reg [`MXIO_ODE_W-1:0] p9_ode_q;

  reg [38:0] out_q;
  reg [38:0] oe_q;
  reg [38:0] pu_q;
  reg [38:0] pd_q;

  wire [5:0] idx;
  wire       wr_en;
  wire       setup;
  reg        hit;
  reg [31:0] rd_d;
  wire [7:0] p4_rd;
  wire [7:0] p7_rd;

  // Read value of a data register: latch when output, pin when input
  function [7:0] port_rd;
    input [7:0] lat;
    input [7:0] dir;
    input [7:0] pin;
    begin
      port_rd = (dir & lat) | (~dir & pin);
    end
  endfunction

  // Narrow ports go through the byte-wide helper, then get trimmed
  assign p4_rd = port_rd({5'h00, p4_lat_q}, {5'h00, port4_direction_reg}, {5'h00, p4_in});
  assign p7_rd = port_rd({4'h0, p7_lat_q}, {4'h0, port7_direction_reg}, {4'h0, p7_in});

  ////////////////////////////////////////////////////////////////////
  // APB decode; always ready, so every access ends in one access cycle
  assign idx    = paddr[`MXIO_IDX_MSB:`MXIO_IDX_LSB];
  assign setup  = psel & ~penable;
  assign wr_en  = psel & penable & pwrite & hit;
  assign pready = 1'b1;
  // Upper address bits must be zero for a hit
  assign pslverr = psel & penable & ~hit;

  // Address hit and read mux; direction/function read as zero
  always @* begin
    hit  = (paddr[`MXIO_ADDR_MSB:`MXIO_IDX_MSB+1] == 4'h0) &
           (paddr[`MXIO_IDX_LSB-1:0] == 2'h0);
    rd_d = 32'h0000_0000;
    case (idx)
      `MXIO_IDX_P3_DATA:
        rd_d[7:0] = port_rd(~p3_lat_q,
                            port3_direction_reg | `MXIO_P3_OUT_ONLY,
                            p3_in);
      `MXIO_IDX_P4_DATA:
        rd_d[7:0] = {`MXIO_P4_RD_ONES, p4_rd[2:0]};
      `MXIO_IDX_P5_IN:
        rd_d[7:0] = p5_in;
      `MXIO_IDX_P6_DATA:
        rd_d[7:0] = port_rd(p6_lat_q, port6_direction_reg, p6_in);
      `MXIO_IDX_P7_DATA:
        rd_d[3:0] = p7_rd[3:0];
      `MXIO_IDX_P8_DATA:
        rd_d[7:0] = port_rd(p8_lat_q, port8_direction_reg, p8_in);
      `MXIO_IDX_P9_DATA:
        rd_d[7:0] = port_rd(p9_lat_q, port9_direction_reg, p9_in);
      `MXIO_IDX_P3_DIR, `MXIO_IDX_P3_FN, `MXIO_IDX_P4_DIR,
      `MXIO_IDX_P4_FN, `MXIO_IDX_P6_DIR, `MXIO_IDX_P6_FN,
      `MXIO_IDX_P7_DIR, `MXIO_IDX_P7_FN, `MXIO_IDX_P8_DIR,
      `MXIO_IDX_P8_FN, `MXIO_IDX_P9_DIR, `MXIO_IDX_P9_FN:
        rd_d = 32'h0000_0000;
      `MXIO_IDX_P9_ODE:
        rd_d[`MXIO_ODE_W-1:0] = p9_ode_q;
      default:
        hit = 1'b0;
    endcase
  end

  // Read data captured in setup, stable through the access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup & ~pwrite) begin
      prdata <= rd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register writes; whole values only, software never merges bits
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p3_lat_q            <= `MXIO_RST_P3_LAT;
      port3_direction_reg <= `MXIO_RST_ZERO8;
      port3_function_reg  <= `MXIO_RST_ZERO8;
      // port 4 pulls up on 0,1 and down on 2
      p4_lat_q            <= `MXIO_RST_P4_LAT;
      port4_direction_reg <= 3'h0;
      port4_function_reg  <= 3'h0;
      p6_lat_q            <= `MXIO_RST_P6_LAT;
      port6_direction_reg <= `MXIO_RST_ZERO8;
      port6_function_reg  <= `MXIO_RST_ZERO8;
      p7_lat_q            <= `MXIO_RST_P7_LAT;
      port7_direction_reg <= 4'h0;
      port7_function_reg  <= 4'h0;
      p8_lat_q            <= `MXIO_RST_P8_LAT;
      port8_direction_reg <= `MXIO_RST_ZERO8;
      port8_function_reg  <= `MXIO_RST_ZERO8;
      // open-drain pair latch and direction one
      p9_lat_q            <= `MXIO_RST_P9_LAT;
      port9_direction_reg <= `MXIO_RST_P9_DIR;
      port9_function_reg  <= `MXIO_RST_ZERO8;
      p9_ode_q            <= 2'h0;
    end else if (wr_en) begin
      case (idx)
        `MXIO_IDX_P3_DATA: p3_lat_q <= pwdata[7:0];
        `MXIO_IDX_P3_DIR:
          port3_direction_reg <= pwdata[7:0] & ~`MXIO_P3_OUT_ONLY;
        `MXIO_IDX_P3_FN:   port3_function_reg  <= pwdata[7:0];
        `MXIO_IDX_P4_DATA: p4_lat_q            <= pwdata[2:0];
        `MXIO_IDX_P4_DIR:  port4_direction_reg <= pwdata[2:0];
        `MXIO_IDX_P4_FN:   port4_function_reg  <= pwdata[2:0];
        `MXIO_IDX_P6_DATA: p6_lat_q            <= pwdata[7:0];
        `MXIO_IDX_P6_DIR:  port6_direction_reg <= pwdata[7:0];
        `MXIO_IDX_P6_FN:   port6_function_reg  <= pwdata[7:0];
        `MXIO_IDX_P7_DATA: p7_lat_q            <= pwdata[3:0];
        `MXIO_IDX_P7_DIR:  port7_direction_reg <= pwdata[3:0];
        `MXIO_IDX_P7_FN:   port7_function_reg  <= pwdata[3:0];
        `MXIO_IDX_P8_DATA: p8_lat_q            <= pwdata[7:0];
        `MXIO_IDX_P8_DIR:  port8_direction_reg <= pwdata[7:0];
        `MXIO_IDX_P8_FN:   port8_function_reg  <= pwdata[7:0];
        `MXIO_IDX_P9_DATA: p9_lat_q            <= pwdata[7:0];
        `MXIO_IDX_P9_DIR:  port9_direction_reg <= pwdata[7:0];
        `MXIO_IDX_P9_FN:   port9_function_reg  <= pwdata[7:0];
        `MXIO_IDX_P9_ODE:  p9_ode_q <= pwdata[`MXIO_ODE_W-1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Peripheral values per pin
  wire       rd_strobe_n;
  wire       wr_strobe_n;
  wire [7:0] p3_alt;
  wire [7:0] p3_dir;
  wire [2:0] p4_fn;
  wire [7:0] p6_alt;
  wire [3:0] p7_alt;
  wire [7:0] p8_alt;
  wire [7:0] p9_alt;
  wire [7:0] p9_od;
  wire [7:0] p9_fn;

  // latch 1 limits strobe to external area
  assign rd_strobe_n = ~(cpu_rd & (ext_area | ~p3_lat_q[0]));
  assign wr_strobe_n = ~(cpu_wr & ext_area);
  assign p3_alt = {p3_alt_out, wr_strobe_n, rd_strobe_n};
  assign p3_dir = port3_direction_reg | `MXIO_P3_OUT_ONLY;
  // chip select needs both direction and function
  assign p4_fn  = port4_function_reg & port4_direction_reg;
  // transmit on 0,3,6, clock on 2,5
  assign p6_alt = {1'b0, p6_txd_out[2], p6_sclk_out[1], 1'b0,
                   p6_txd_out[1], p6_sclk_out[0], 1'b0, p6_txd_out[0]};
  // timer and PWM on bits 1 to 3
  assign p7_alt = {pwm1_output, pwm0_output, timer1_output, 1'b0};
  assign p8_alt = {1'b0, timer_ff_out[2], 2'b00,
                   timer_ff_out[1:0], 2'b00};
  assign p9_alt = {2'b00, p9_sclk_out[1], 1'b0, p9_txd_out[1],
                   p9_sclk_out[0], 1'b0, p9_txd_out[0]};
  assign p9_fn  = port9_function_reg & `MXIO_P9_PU_MASK;
  assign p9_od  = `MXIO_P9_OD_FIXED |
                  {4'h0, p9_ode_q[1], 2'b00, p9_ode_q[0]};

  ////////////////////////////////////////////////////////////////////
  // Pin muxes; port 3 latch is stored inverted toward the pin
  wire [38:0] o_d;
  wire [38:0] oe_d;
  wire [38:0] pu_d;
  wire [38:0] pd_d;

  mxio_pin #(.W(8)) u_p3 (
    .lat     (~p3_lat_q),
    .dir     (p3_dir),
    .fn      (port3_function_reg),
    .alt     (p3_alt),
    .od      (8'h00),
    .pu_mask (`MXIO_ALL_ONES8),
    .pd_mask (8'h00),
    .pin_o   (o_d[7:0]),
    .pin_oe  (oe_d[7:0]),
    .pu_en   (pu_d[7:0]),
    .pd_en   (pd_d[7:0])
  );

  mxio_pin #(.W(3)) u_p4 (
    .lat     (p4_lat_q),
    .dir     (port4_direction_reg),
    .fn      (p4_fn),
    .alt     (bank_select_outputs),
    .od      (3'h0),
    .pu_mask (`MXIO_P4_PU_MASK),
    .pd_mask (`MXIO_P4_PD_MASK),
    .pin_o   (o_d[10:8]),
    .pin_oe  (oe_d[10:8]),
    .pu_en   (pu_d[10:8]),
    .pd_en   (pd_d[10:8])
  );

  mxio_pin #(.W(8)) u_p6 (
    .lat     (p6_lat_q),
    .dir     (port6_direction_reg),
    .fn      (port6_function_reg),
    .alt     (p6_alt),
    .od      (8'h00),
    .pu_mask (`MXIO_ALL_ONES8),
    .pd_mask (8'h00),
    .pin_o   (o_d[18:11]),
    .pin_oe  (oe_d[18:11]),
    .pu_en   (pu_d[18:11]),
    .pd_en   (pd_d[18:11])
  );

  mxio_pin #(.W(4)) u_p7 (
    .lat     (p7_lat_q),
    .dir     (port7_direction_reg),
    .fn      (port7_function_reg),
    .alt     (p7_alt),
    .od      (4'h0),
    .pu_mask (4'hf),
    .pd_mask (4'h0),
    .pin_o   (o_d[22:19]),
    .pin_oe  (oe_d[22:19]),
    .pu_en   (pu_d[22:19]),
    .pd_en   (pd_d[22:19])
  );

  mxio_pin #(.W(8)) u_p8 (
    .lat     (p8_lat_q),
    .dir     (port8_direction_reg),
    .fn      (port8_function_reg),
    .alt     (p8_alt),
    .od      (8'h00),
    .pu_mask (`MXIO_ALL_ONES8),
    .pd_mask (8'h00),
    .pin_o   (o_d[30:23]),
    .pin_oe  (oe_d[30:23]),
    .pu_en   (pu_d[30:23]),
    .pd_en   (pd_d[30:23])
  );

  // Oscillator pair has no pull-up
  mxio_pin #(.W(8)) u_p9 (
    .lat     (p9_lat_q),
    .dir     (port9_direction_reg),
    .fn      (p9_fn),
    .alt     (p9_alt),
    .od      (p9_od),
    .pu_mask (`MXIO_P9_PU_MASK),
    .pd_mask (8'h00),
    .pin_o   (o_d[38:31]),
    .pin_oe  (oe_d[38:31]),
    .pu_en   (pu_d[38:31]),
    .pd_en   (pd_d[38:31])
  );

  ////////////////////////////////////////////////////////////////////
  // pin controls registered, follow writes one edge later
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // bits 0,1 high, others inputs: pulled up, except bit 10 pulled down and 37,38 unpulled
      out_q <= `MXIO_RST_PIN_OUT;
      oe_q  <= `MXIO_RST_PIN_OUT;
      pu_q  <= `MXIO_RST_PIN_PU;
      pd_q  <= `MXIO_RST_PIN_PD;
    end else begin
      out_q <= o_d;
      oe_q  <= oe_d;
      pu_q  <= pu_d;
      pd_q  <= pd_d;
    end
  end

  assign pin_o  = out_q;
  assign pin_oe = oe_q;
  assign pin_pu = pu_q;
  assign pin_pd = pd_q;

  ////////////////////////////////////////////////////////////////////
  // Inputs with no selector always reach their peripherals
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port5_input_levels  <= 8'h00;
      serial_rxd_p6       <= 3'h7;
      serial_rxd_p9       <= 2'h3;
      timer0_clock_input  <= 1'b0;
      timer16_clk_in      <= 4'h0;
      external_irq0_input <= 1'b1;
      slow_osc_in         <= 1'b0;
    end else begin
      port5_input_levels  <= p5_in;
      serial_rxd_p6       <= {p6_in[7], p6_in[4], p6_in[1]};
      serial_rxd_p9       <= {p9_in[4], p9_in[1]};
      timer0_clock_input  <= p7_in[0];
      timer16_clk_in      <= {p8_in[5:4], p8_in[1:0]};
      // level follows pin; enable lives elsewhere
      external_irq0_input <= p8_in[7];
      slow_osc_in         <= p9_in[6];
    end
  end

endmodule // mxio_ports

// >>> sim/mxio_chk_checker.sv
// Concurrent checks tying the port bank's outputs to its inputs.
// Assumes it is bound into mxio_ports and sees only that module's ports.
module mxio_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic [7:0]  p5_in,
  input wire logic [7:0]  p6_in,
  input wire logic [3:0]  p7_in,
  input wire logic [7:0]  p8_in,
  input wire logic [7:0]  p9_in,
  input wire logic [38:0] pin_o,
  input wire logic [38:0] pin_oe,
  input wire logic [7:0]  port5_input_levels,
  input wire logic [2:0]  serial_rxd_p6,
  input wire logic        timer0_clock_input,
  input wire logic [3:0]  timer16_clk_in,
  input wire logic        slow_osc_in,
  input wire logic [1:0]  serial_rxd_p9,
  input wire logic        external_irq0_input
);
  // Access decodes and input groups; the $past guard skips the edge after reset
  wire       rd_p4 = psel && penable && !pwrite && paddr == 12'h00c;
  wire       wr_d6 = psel && penable && pwrite && paddr == 12'h01c;
  wire [2:0] rx6   = {p6_in[7], p6_in[4], p6_in[1]};
  wire [3:0] t16   = {p8_in[5:4], p8_in[1:0]};
  wire [1:0] rx9   = {p9_in[4], p9_in[1]};

  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_p3_out_only: assert property (pin_oe[1:0] == 2'b11)
    else $error("port 3 bits 0 or 1 not driven");
  chk_od_never_high: assert property (pin_o[38:37] == 2'b00)
    else $error("open-drain pin driven high");
  chk_dir_latency: assert property (wr_d6 |=> ##1 pin_oe[18:11] == $past(pwdata[7:0], 2))
    else $error("port 6 drive enable late or wrong");
  chk_p4_ones: assert property (rd_p4 |-> prdata[7:3] == 5'h1f)
    else $error("port 4 upper read bits not ones");
  chk_p5_follow: assert property ($past(presetn) |-> port5_input_levels == $past(p5_in))
    else $error("port 5 levels do not follow pins");
  chk_t0_route: assert property ($past(presetn) |-> timer0_clock_input == $past(p7_in[0]))
    else $error("timer 0 clock not routed");
  chk_t16_route: assert property ($past(presetn) |-> timer16_clk_in == $past(t16))
    else $error("16-bit timer clocks not routed");
  chk_rx6_route: assert property ($past(presetn) |-> serial_rxd_p6 == $past(rx6))
    else $error("port 6 receive data not routed");
  chk_osc_route: assert property ($past(presetn) |-> slow_osc_in == $past(p9_in[6]))
    else $error("slow oscillator input not routed");
  chk_irq0_route: assert property ($past(presetn) |-> external_irq0_input == $past(p8_in[7]))
    else $error("interrupt 0 pin level not routed");
  chk_rx9_route: assert property ($past(presetn) |-> serial_rxd_p9 == $past(rx9))
    else $error("port 9 receive data not routed");
endmodule // mxio_chk

bind mxio_ports mxio_chk u_chk (.*);

// >>> sim/mxio_pad_model.sv
// Board model: pad drivers, external drivers and pulls resolved to levels.
// Assumes pad controls from mxio_ports and board values from the bench.
module mxio_pad_model (
  input  wire logic        pclk,
  input  wire logic [38:0] pin_o,
  input  wire logic [38:0] pin_oe,
  input  wire logic [38:0] pin_pu,
  input  wire logic [38:0] pin_pd,
  input  wire logic [38:0] ext_lvl,
  input  wire logic [38:0] ext_en,
  input  wire logic [7:0]  p5_ext,
  output wire logic [7:0]  p3_in,
  output wire logic [2:0]  p4_in,
  output wire logic [7:0]  p5_in,
  output wire logic [7:0]  p6_in,
  output wire logic [3:0]  p7_in,
  output wire logic [7:0]  p8_in,
  output wire logic [7:0]  p9_in
);
  logic [38:0] lvl;
  logic [38:0] lvl_q = '0;
  // pad wins; an unheld, unpulled pin flips so no stale level survives
  assign lvl = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_lvl)
             | (~pin_oe & ~ext_en & (pin_pu | (~pin_pd & ~lvl_q)));
  always_ff @(posedge pclk) lvl_q <= lvl;
  // Pin groups back to the ports
  assign p3_in = lvl[7:0];
  assign p4_in = lvl[10:8];
  assign p5_in = p5_ext;
  assign p6_in = lvl[18:11];
  assign p7_in = lvl[22:19];
  assign p8_in = lvl[30:23];
  assign p9_in = lvl[38:31];
endmodule // mxio_pad_model

// >>> sim/tb.sv
// Self-checking bench for the I/O port bank over APB with a board model.
// Assumes mxio_ports, mxio_pad_model and the bound checker are compiled.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        cpu_rd, cpu_wr, ext_area, timer1_output, pwm0_output, pwm1_output;
  logic        timer0_clock_input, external_irq0_input, slow_osc_in;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:2]  p3_alt_out;
  logic [2:0]  bank_select_outputs, p6_txd_out, timer_ff_out, p4_in, serial_rxd_p6;
  logic [1:0]  p6_sclk_out, p9_txd_out, p9_sclk_out, serial_rxd_p9;
  logic [7:0]  p3_in, p5_in, p6_in, p8_in, p9_in, port5_input_levels, p5_ext, d, l, f, eoe;
  logic [3:0]  p7_in, timer16_clk_in;
  logic [38:0] pin_o, pin_oe, pin_pu, pin_pd, ext_lvl, ext_en, w;
  logic [5:0]  di[4] = '{6'h06, 6'h09, 6'h0c, 6'h10};
  logic [5:0]  dr[4] = '{6'h07, 6'h0a, 6'h0e, 6'h11};
  logic [5:0]  fi[4] = '{6'h08, 6'h0b, 6'h0f, 6'h12};
  logic [38:0] wm[4] = '{39'hff, 39'h0f, 39'hff, 39'hff};
  int          lo[4] = '{11, 19, 23, 31};
  int          bad_count, checks_done, cyc, p;
  integer      seed;

  mxio_ports dut (.*);
  mxio_pad_model board (.*);

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [38:0] seen, input logic [38:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  function automatic logic [38:0] rnd39;
    logic [63:0] v;
    v = {$random(seed), $random(seed)};
    return v[38:0];
  endfunction

  // whole words only; held until pready is seen
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {4'h0, idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // New peripheral and board values, held until the next call
  task automatic shake;
    w = rnd39();
    {p3_alt_out, p6_txd_out, p6_sclk_out, timer1_output, pwm0_output, pwm1_output,
     timer_ff_out, p9_txd_out, p9_sclk_out, bank_select_outputs, cpu_wr} <= w[24:0];
    p5_ext <= w[38:31];
    ext_lvl <= rnd39();
    ext_en <= rnd39();
  endtask

  // Hang guard; a clean run needs about a tenth of this
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h69fc_2be7;
    {presetn, psel, penable, pwrite, cpu_rd, ext_area} = '0;
    {paddr, pwdata} = '0;
    shake();
    // Second pass starts with a reset in mid-run
    repeat (2) begin
      presetn <= 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      @(negedge pclk);
      check(pin_oe, 39'h3);
      check(pin_pu, 39'h1f_ffff_fbfc);
      check(pin_pd, 39'h400);
      check(pin_o[1:0], 2'b11);
      apb(1'b0, 6'h03, 32'h0);
      check(rd[31:3], 29'h1f);
      for (p = 0; p < 4; p++) begin
        apb(1'b1, dr[p], 32'hff);
        apb(1'b0, di[p], 32'h0);
        check(rd, wm[p]);
      end
      // latch drives outputs, switches pulls on inputs
      for (int i = 0; i < 24; i++) begin
        p = i % 4;
        w = rnd39();
        d = w[7:0] & wm[p][7:0];
        l = w[15:8] & wm[p][7:0];
        apb(1'b1, di[p], {24'h0, l});
        apb(1'b1, dr[p], {24'h0, d});
        apb(1'b1, fi[p], 32'h0);
        @(posedge pclk);
        @(negedge pclk);
        eoe = (p == 3) ? {d[7:6] & ~l[7:6], d[5:0]} : d;
        check((pin_oe >> lo[p]) & wm[p], {31'h0, eoe});
        check((pin_pu >> lo[p]) & wm[p], {31'h0, ~d & l & ((p == 3) ? 8'h3f : 8'hff)});
        check((pin_o >> lo[p]) & {31'h0, eoe}, {31'h0, l & eoe});
        apb(1'b0, di[p], 32'h0);
        check({31'h0, rd[7:0] & d}, {31'h0, l & d});
      end
      // read strobe by latch, read and area
      // wait pin kept an input while its neighbours drive
      apb(1'b1, 6'h01, 32'hf7);
      apb(1'b1, 6'h02, 32'h3);
      for (int k = 0; k < 8; k++) begin
        if (k % 4 == 0) apb(1'b1, 6'h00, {31'h0, k[2]});
        @(posedge pclk);
        {cpu_rd, ext_area} <= k[1:0];
        @(posedge pclk);
        @(negedge pclk);
        check(pin_o[0], !(k[1] && (!k[2] || k[0])));
        check(pin_o[1], !(cpu_wr && k[0]));
        check(pin_oe[7:2], 6'h3d);
      end
      for (int k = 0; k < 8; k++) begin
        f = k[0] ? 8'hff : 8'h00;
        apb(1'b1, 6'h04, 32'h7);
        apb(1'b1, 6'h05, {24'h0, f});
        apb(1'b1, 6'h03, 32'h0);
        for (p = 0; p < 4; p++) begin
          apb(1'b1, dr[p], 32'hff);
          apb(1'b1, fi[p], {24'h0, f});
          apb(1'b1, di[p], 32'h0);
        end
        apb(1'b1, 6'h13, {30'h0, k[2], k[2]});
        shake();
        @(posedge pclk);
        @(negedge pclk);
        check({pin_o[10:8], pin_o[17], pin_o[14], pin_o[11], pin_o[16], pin_o[13],
               pin_o[22:20], pin_o[29], pin_o[26:25], pin_o[34], pin_o[31], pin_o[36],
               pin_o[33]}, {bank_select_outputs, p6_txd_out, p6_sclk_out, pwm1_output,
               pwm0_output, timer1_output, timer_ff_out, p9_txd_out & ~{2{k[2]}},
               p9_sclk_out} & {18{k[0]}});
        if (k[0]) check({pin_oe[34], pin_oe[31]}, k[2] ? {~p9_txd_out} : 2'b11);
      end
      // port 5 shows its pins and ignores writes
      repeat (4) begin
        shake();
        apb(1'b1, 6'h0d, 32'h0);
        apb(1'b0, 6'h0d, 32'h0);
        check(rd, {24'h0, p5_ext});
      end
      // Unmapped place answers with an error and zero data
      apb(1'b0, 6'h14, 32'h0);
      check({err, rd}, {1'b1, 32'h0});
    end
    close_out();
  end
endmodule // tb
